// File: logic/ubc_pkg.sv
// package: register map, field positions and rate constants of the uart control block
package ubc_pkg;
  // ==========================================================
  // register offsets on the byte register port
  localparam logic [7:0] UBC_SC_ADDR = 8'h98; // serial_control
  localparam logic [7:0] UBC_RELOAD_ADDR = 8'h9a; // internal_reload_value
  localparam logic [7:0] UBC_BAUD_ADDR = 8'h9b; // baud_control
  localparam logic [7:0] UBC_PWR_ADDR = 8'h87; // power_control
  localparam logic [7:0] UBC_T1_RELOAD_ADDR = 8'h8d; // t1_reload_byte
  localparam logic [7:0] UBC_T1_CTL_ADDR = 8'h88; // t1_control
  // ==========================================================
  // serial_control fields
  localparam int UBC_SC_B7 = 7; // framing_error or mode_sel_hi
  localparam int UBC_SC_SM1 = 6; // mode_sel_lo
  localparam int UBC_SC_MPE = 5; // multiproc_enable
  localparam int UBC_SC_REN = 4; // rx_enable
  localparam int UBC_SC_TB8 = 3; // tx_ninth_bit
  localparam int UBC_SC_RB8 = 2; // rx_ninth_bit
  localparam int UBC_SC_TI = 1; // tx_done_flag
  localparam int UBC_SC_RI = 0; // rx_done_flag
  // baud_control fields
  localparam int UBC_BC_BRR = 4; // brg_run
  localparam int UBC_BC_TX_SOURCE_SELECT = 3; // tx_source_select
  localparam int UBC_BC_RX_SOURCE_SELECT = 2; // rx_source_select
  localparam int UBC_BC_SPD = 1; // fast_clock_select
  localparam int UBC_BC_M0 = 0; // mode0_source_select
  // power_control fields
  localparam int UBC_PC_RATE_DOUBLE = 7; // rate_double
  localparam int UBC_PC_FRAME_CHECK_ENABLE = 6; // frame_check_enable
  // t1_control fields
  localparam int UBC_T1_RUN = 0; // timer 1 run
  // ==========================================================
  // reset values
  localparam logic [7:0] UBC_RST8 = 8'h00;
  localparam logic [4:0] UBC_RST_BAUD = 5'h00;
  // ==========================================================
  // rate constants
  localparam logic [2:0] UBC_DIV6_LAST = 3'h5; // clock / 6 prescale
  localparam logic [4:0] UBC_PRE_LAST_X1 = 5'h1f; // 32 events per bit
  localparam logic [4:0] UBC_PRE_LAST_X2 = 5'h0f; // 16 events per bit
  localparam logic [7:0] UBC_CNT_TOP = 8'hff; // 8-bit overflow point
  // ==========================================================
  // serial modes
  typedef enum logic [1:0] {
    UBC_MODE_SHIFT = 2'b00,
    UBC_MODE_UART8 = 2'b01,
    UBC_MODE_UART9F = 2'b10,
    UBC_MODE_UART9V = 2'b11
  } ubc_mode_e;
endpackage

// File: logic/ubc_gen_if.sv
// interface: control and overflow of one 8-bit auto-reload rate generator
`timescale 1ns/1ps
`default_nettype none
interface ubc_gen_if;
  logic [7:0] reload; // auto-reload value
  logic run; // count enable
  logic slow; // prescale the clock by 6
  logic ovf; // one-cycle overflow pulse
  modport ctl (output reload, output run, output slow, input ovf);
  modport gen (input reload, input run, input slow, output ovf);
endinterface
`default_nettype wire

// File: logic/ubc_rate_gen.sv
// module: 8-bit auto-reload overflow generator with optional clock / 6
`timescale 1ns/1ps
`default_nettype none
module ubc_rate_gen
  import ubc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control and overflow
  ubc_gen_if.gen g
);
  // ==========================================================
  // state
  logic [2:0] pre; // clock / 6 prescaler
  logic [7:0] cnt; // up counter
  logic ovf_q; // registered overflow
  logic [2:0] next_pre;
  logic [7:0] next_cnt;
  logic next_ovf;
  logic step;

  // next-state: stopped generator holds the reload value so it restarts
  // with a full period rather than a stale fraction of one
  always_comb begin
    next_pre = pre;
    next_cnt = cnt;
    next_ovf = 1'b0;
    step = 1'b0;
    if (!g.run) begin
      next_pre = 3'h0;
      next_cnt = g.reload;
    end else begin
      // slow mode steps once every six clocks
      if (g.slow) begin
        step = (pre == UBC_DIV6_LAST);
        next_pre = step ? 3'h0 : pre + 3'h1;
      end else begin
        step = 1'b1;
      end
      if (step) begin
        if (cnt == UBC_CNT_TOP) begin
          next_cnt = g.reload;
          next_ovf = 1'b1;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pre <= 3'h0;
      cnt <= 8'h00;
      ovf_q <= 1'b0;
    end else begin
      pre <= next_pre;
      cnt <= next_cnt;
      ovf_q <= next_ovf;
    end
  end

  assign g.ovf = ovf_q;
endmodule
`default_nettype wire

// File: logic/ubc_uart_ctl.sv
// module: uart bit-rate source selection with serial control and status
// Function
// - modes 1,3: timer 1 or generator per direction
// - rx/tx sources from baud_control select bits
// - generator rate: clock, doubling, reload, slow divide
// - timer 1 rate: clock/6/32, reload, doubling
// - mode 2: clock/32, or /16 doubled
// - mode 0 source from mode0_source_select
// - bit 7 is framing_error or mode_sel_hi
// - framing_error sticky until software clears
// - mode field selects four serial modes
// - multiproc_enable for modes 1-3, not 0
// - reception only while rx_enable set
// - tx_ninth_bit sent as ninth bit
// - rx_ninth_bit: ninth bit or mode 1 stop
// - tx_done_flag set at transmit end event
// - rx_done_flag set at receive end event
// - source select: clear timer 1, set generator
// - generator counts only while brg_run set
// - fast_clock_select clear divides clock by 6
// - timer 1 auto-reloads from t1_reload_byte
`timescale 1ns/1ps
`default_nettype none
module ubc_uart_ctl
  import ubc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // events from the frame shifter (same clock)
  input wire logic tx_end,
  input wire logic rx_end,
  input wire logic rx_bit9,
  input wire logic rx_stop_bit,
  input wire logic rx_stop_bad,
  // control to the frame shifter
  output logic [1:0] mode,
  output logic rx_enable,
  output logic multiproc_enable,
  output logic tx_ninth_bit,
  output logic tx_bit_tick,
  output logic rx_bit_tick,
  // status flags
  output logic tx_done_flag,
  output logic rx_done_flag,
  output logic framing_error
);
  // ==========================================================
  // register state
  logic mode_sel_hi, mode_sel_lo, rx_ninth_bit;
  logic [7:0] internal_reload_value, t1_reload_byte;
  logic [4:0] baud_control;
  logic rate_double, frame_check_enable, t1_run;
  logic next_hi, next_lo, next_mpe, next_ren, next_tb8, next_rb8;
  logic next_ti, next_ri, next_fe;
  logic [7:0] next_reload, next_t1_reload, next_rdata;
  logic [4:0] next_baud;
  logic next_rate_double, next_frame_check_enable, next_t1_run;
  logic sc_wr; // write to serial_control this cycle
  logic rx_ok; // receive event accepted
  ubc_mode_e cur_mode;

  assign cur_mode = ubc_mode_e'({mode_sel_hi, mode_sel_lo});
  assign sc_wr = wr_en && (addr == UBC_SC_ADDR);
  // receive events are dropped while reception is disabled
  assign rx_ok = rx_end && rx_enable;

  // ==========================================================
  // register next values: software writes first, hardware sets after
  always_comb begin
    next_hi = mode_sel_hi;
    next_lo = mode_sel_lo;
    next_mpe = multiproc_enable;
    next_ren = rx_enable;
    next_tb8 = tx_ninth_bit;
    next_rb8 = rx_ninth_bit;
    next_ti = tx_done_flag;
    next_ri = rx_done_flag;
    next_fe = framing_error;
    next_reload = internal_reload_value;
    next_t1_reload = t1_reload_byte;
    next_baud = baud_control;
    next_rate_double = rate_double;
    next_frame_check_enable = frame_check_enable;
    next_t1_run = t1_run;
    if (wr_en) begin
      if (addr == UBC_SC_ADDR) begin
        // bit 7 lands on the flag or the mode bit by the view selector
        if (frame_check_enable) begin
          next_fe = wdata[UBC_SC_B7];
        end else begin
          next_hi = wdata[UBC_SC_B7];
        end
        next_lo = wdata[UBC_SC_SM1];
        next_mpe = wdata[UBC_SC_MPE];
        next_ren = wdata[UBC_SC_REN];
        next_tb8 = wdata[UBC_SC_TB8];
        next_rb8 = wdata[UBC_SC_RB8];
        next_ti = wdata[UBC_SC_TI];
        next_ri = wdata[UBC_SC_RI];
      end else if (addr == UBC_RELOAD_ADDR) begin
        next_reload = wdata;
      end else if (addr == UBC_BAUD_ADDR) begin
        next_baud = wdata[4:0];
      end else if (addr == UBC_PWR_ADDR) begin
        next_rate_double = wdata[UBC_PC_RATE_DOUBLE];
        next_frame_check_enable = wdata[UBC_PC_FRAME_CHECK_ENABLE];
      end else if (addr == UBC_T1_RELOAD_ADDR) begin
        next_t1_reload = wdata;
      end else if (addr == UBC_T1_CTL_ADDR) begin
        next_t1_run = wdata[UBC_T1_RUN];
      end
    end
    // hardware sets come last so a same-cycle clear loses
    if (tx_end) begin
      next_ti = 1'b1;
    end
    if (rx_ok) begin
      next_ri = 1'b1;
      // ninth bit in modes 2 and 3, stop bit in mode 1 without mpe
      if (mode_sel_hi) begin
        next_rb8 = rx_bit9;
      end else if (mode_sel_lo && !multiproc_enable) begin
        next_rb8 = rx_stop_bit;
      end
      // a bad stop bit latches; a good one never clears it
      if (frame_check_enable && rx_stop_bad &&
          cur_mode != UBC_MODE_SHIFT) begin
        next_fe = 1'b1;
      end
    end
  end

  // ==========================================================
  // read data: registered, valid the cycle after the strobe only
  always_comb begin
    next_rdata = 8'h00;
    if (rd_en) begin
      if (addr == UBC_SC_ADDR) begin
        next_rdata = {(frame_check_enable ? framing_error : mode_sel_hi),
                      mode_sel_lo, multiproc_enable, rx_enable,
                      tx_ninth_bit, rx_ninth_bit, tx_done_flag,
                      rx_done_flag};
      end else if (addr == UBC_RELOAD_ADDR) begin
        next_rdata = internal_reload_value;
      end else if (addr == UBC_BAUD_ADDR) begin
        next_rdata = {3'h0, baud_control};
      end else if (addr == UBC_PWR_ADDR) begin
        next_rdata = {rate_double, frame_check_enable, 6'h00};
      end else if (addr == UBC_T1_RELOAD_ADDR) begin
        next_rdata = t1_reload_byte;
      end else if (addr == UBC_T1_CTL_ADDR) begin
        next_rdata = {7'h00, t1_run};
      end
    end
  end

  // register update
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_sel_hi <= 1'b0;
      mode_sel_lo <= 1'b0;
      multiproc_enable <= 1'b0;
      rx_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      rx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      framing_error <= 1'b0;
      internal_reload_value <= UBC_RST8;
      t1_reload_byte <= UBC_RST8;
      baud_control <= UBC_RST_BAUD;
      rate_double <= 1'b0;
      frame_check_enable <= 1'b0;
      t1_run <= 1'b0;
      rdata <= 8'h00;
    end else begin
      mode_sel_hi <= next_hi;
      mode_sel_lo <= next_lo;
      multiproc_enable <= next_mpe;
      rx_enable <= next_ren;
      tx_ninth_bit <= next_tb8;
      rx_ninth_bit <= next_rb8;
      tx_done_flag <= next_ti;
      rx_done_flag <= next_ri;
      framing_error <= next_fe;
      internal_reload_value <= next_reload;
      t1_reload_byte <= next_t1_reload;
      baud_control <= next_baud;
      rate_double <= next_rate_double;
      frame_check_enable <= next_frame_check_enable;
      t1_run <= next_t1_run;
      rdata <= next_rdata;
    end
  end

  assign mode = {mode_sel_hi, mode_sel_lo};

  // ==========================================================
  // overflow sources
  ubc_gen_if brg_if ();
  ubc_gen_if t1_if ();
  assign brg_if.reload = internal_reload_value;
  assign brg_if.run = baud_control[UBC_BC_BRR];
  assign brg_if.slow = !baud_control[UBC_BC_SPD];
  // timer 1 always sees clock / 6 and reloads in 8-bit mode
  assign t1_if.reload = t1_reload_byte;
  assign t1_if.run = t1_run;
  assign t1_if.slow = 1'b1;

  ubc_rate_gen u_brg (.clock(clock), .rst(rst), .g(brg_if.gen));
  ubc_rate_gen u_t1 (.clock(clock), .rst(rst), .g(t1_if.gen));

  // ==========================================================
  // fixed clock / 6 shift tick for mode 0
  logic [2:0] m0_div, next_m0_div;
  logic m0_fixed;
  always_comb begin
    m0_fixed = (m0_div == UBC_DIV6_LAST);
    next_m0_div = m0_fixed ? 3'h0 : m0_div + 3'h1;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      m0_div <= 3'h0;
    end else begin
      m0_div <= next_m0_div;
    end
  end

  // ==========================================================
  // per-direction bit tick: 0 transmit, 1 receive
  logic pre_last_sel; // 16 events per bit when doubled
  assign pre_last_sel = rate_double;
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dir
      logic [4:0] pre, next_pre;
      logic evt, use_brg, tick;
      logic tick_q; // registered tick, one owner per direction
      // each direction picks its own source: clear timer 1, set generator
      assign use_brg = (d == 0) ? baud_control[UBC_BC_TX_SOURCE_SELECT]
                                : baud_control[UBC_BC_RX_SOURCE_SELECT];
      always_comb begin
        evt = 1'b0;
        tick = 1'b0;
        next_pre = pre;
        case (cur_mode)
          UBC_MODE_SHIFT: begin
            // fixed path bypasses the prescaler entirely
            if (baud_control[UBC_BC_M0]) begin
              evt = brg_if.ovf;
            end else begin
              tick = m0_fixed;
            end
          end
          UBC_MODE_UART9F: begin
            evt = 1'b1;
          end
          default: begin
            evt = use_brg ? brg_if.ovf : t1_if.ovf;
          end
        endcase
        if (evt) begin
          // divide events by 32, or 16 when doubled
          if (pre == (pre_last_sel ? UBC_PRE_LAST_X2
                                   : UBC_PRE_LAST_X1)) begin
            next_pre = 5'h00;
            tick = 1'b1;
          end else begin
            next_pre = pre + 5'h01;
          end
        end
      end
      always_ff @(posedge clock) begin
        if (rst) begin
          pre <= 5'h00;
          tick_q <= 1'b0;
        end else begin
          pre <= next_pre;
          tick_q <= tick;
        end
      end
    end
  endgenerate
  assign tx_bit_tick = g_dir[0].tick_q;
  assign rx_bit_tick = g_dir[1].tick_q;

  // ==========================================================
  // checks
  sequence s_sc_read;
    rd_en && addr == UBC_SC_ADDR;
  endsequence
  // a tick seen on a write edge belongs to the old setting, so skip it
  sequence s_m2_slow_tick;
    tx_bit_tick && cur_mode == UBC_MODE_UART9F && !rate_double && !wr_en;
  endsequence

  chk_brg_stopped: assert property (@(posedge clock) disable iff (rst)
    !baud_control[UBC_BC_BRR] |=> !brg_if.ovf)
    else $error("generator overflowed while stopped");
  chk_mode2_slow: assert property (@(posedge clock)
    disable iff (rst || wr_en)
    s_m2_slow_tick |=> !tx_bit_tick[*8] ##24 tx_bit_tick)
    else $error("mode 2 slow bit period is not 32 clocks");
  chk_mode2_fast: assert property (@(posedge clock)
    disable iff (rst || wr_en)
    tx_bit_tick && cur_mode == UBC_MODE_UART9F && rate_double && !wr_en
      |=> !tx_bit_tick[*8] ##8 tx_bit_tick)
    else $error("mode 2 fast bit period is not 16 clocks");
  chk_m0_fixed: assert property (@(posedge clock)
    disable iff (rst || wr_en)
    tx_bit_tick && cur_mode == UBC_MODE_SHIFT &&
      !baud_control[UBC_BC_M0] && !wr_en |-> ##6 tx_bit_tick)
    else $error("mode 0 fixed shift period is not 6 clocks");
  chk_bit7_view: assert property (@(posedge clock) disable iff (rst)
    s_sc_read |=>
      rdata[7] == $past(frame_check_enable ? framing_error
                                           : mode_sel_hi))
    else $error("serial control bit 7 shows the wrong view");
  chk_fe_sticky: assert property (@(posedge clock) disable iff (rst)
    framing_error && !(sc_wr && frame_check_enable) |=> framing_error)
    else $error("framing error cleared without software");
  chk_tx_set_wins: assert property (@(posedge clock) disable iff (rst)
    tx_end |=> tx_done_flag)
    else $error("transmit end did not set the done flag");
  chk_rx_ignored: assert property (@(posedge clock) disable iff (rst)
    !rx_enable && !sc_wr |=> $stable(rx_done_flag) && $stable(framing_error))
    else $error("receive event taken while reception disabled");
  chk_rb8_load: assert property (@(posedge clock) disable iff (rst)
    rx_ok && mode_sel_hi |=> rx_ninth_bit == $past(rx_bit9))
    else $error("ninth bit not loaded in modes 2 and 3");
endmodule
`default_nettype wire

// File: tb/ubc_shifter_model.sv
// partner model: frame shifter side that raises transmit and receive events
`timescale 1ns/1ps
`default_nettype none
module ubc_shifter_model (
  // clock
  input wire logic clock,
  // events toward the control block
  output logic tx_end,
  output logic rx_end,
  output logic rx_bit9,
  output logic rx_stop_bit,
  output logic rx_stop_bad
);
  // ==========================================================
  // idle levels; qualifiers carry no meaning outside rx_end
  initial begin
    tx_end = 1'b0;
    rx_end = 1'b0;
    rx_bit9 = 1'b0;
    rx_stop_bit = 1'b0;
    rx_stop_bad = 1'b0;
  end
  // one-cycle transmit event after gap idle cycles (slow answers)
  task automatic send_tx(input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    tx_end <= 1'b1;
    @(posedge clock);
    tx_end <= 1'b0;
  endtask
  // one received frame; qualifiers flip once released so stale
  // values never look valid
  task automatic recv(input int gap, input logic b9, input logic st,
                      input logic bad);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    rx_end <= 1'b1;
    rx_bit9 <= b9;
    rx_stop_bit <= st;
    rx_stop_bad <= bad;
    @(posedge clock);
    rx_end <= 1'b0;
    rx_bit9 <= ~b9;
    rx_stop_bit <= ~st;
    rx_stop_bad <= ~bad;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_ubc_uart_ctl.sv
// testbench: register, flag and bit-rate checks of the uart control block
`timescale 1ns/1ps
`default_nettype none
module tb_ubc_uart_ctl
  import ubc_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic tx_end, rx_end, rx_bit9, rx_stop_bit, rx_stop_bad;
  logic [1:0] mode;
  logic rx_enable, multiproc_enable, tx_ninth_bit;
  logic tx_bit_tick, rx_bit_tick;
  logic tx_done_flag, rx_done_flag, framing_error;
  int mismatches = 0; // failed comparisons
  int check_count = 0; // all comparisons
  int n; // measured tick period
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // ==========================================================
  // design and partner
  ubc_uart_ctl dut_u (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .tx_end(tx_end), .rx_end(rx_end), .rx_bit9(rx_bit9),
    .rx_stop_bit(rx_stop_bit), .rx_stop_bad(rx_stop_bad),
    .mode(mode), .rx_enable(rx_enable),
    .multiproc_enable(multiproc_enable), .tx_ninth_bit(tx_ninth_bit),
    .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick),
    .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag),
    .framing_error(framing_error));
  ubc_shifter_model shm_u (.clock(clock), .tx_end(tx_end),
    .rx_end(rx_end), .rx_bit9(rx_bit9), .rx_stop_bit(rx_stop_bit),
    .rx_stop_bad(rx_stop_bad));
  // ==========================================================
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare one value, four-state exact
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  // spacing between the second and third ticks; earlier ones may carry old phase
  task automatic period(input bit tx, output int p);
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin
        @(posedge clock);
        #1 p++;
        if (p > 1000) begin
          chk("tick wait", 16'h0, 16'h1);
          complete_run();
        end
      end while ((tx ? tx_bit_tick : rx_bit_tick) !== 1'b1);
    end
  endtask
  // configure power, baud and serial control, then time one tick
  task automatic rate(input logic [7:0] pc, input logic [7:0] bd,
                      input logic [7:0] sc, input bit tx, input int e);
    wr(UBC_PWR_ADDR, pc);
    wr(UBC_BAUD_ADDR, bd);
    wr(UBC_SC_ADDR, sc);
    period(tx, n);
    chk("tick period", n[15:0], e[15:0]);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] v;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // reset values, mode output reads zero
    rd(UBC_SC_ADDR, 8'h00);
    rd(UBC_BAUD_ADDR, 8'h00);
    rd(UBC_PWR_ADDR, 8'h00);
    chk("mode", {14'h0, mode}, 16'h0);
    // reserved bits read zero, unmapped writes ignored
    wr(UBC_BAUD_ADDR, 8'hff);
    rd(UBC_BAUD_ADDR, 8'h1f);
    wr(UBC_PWR_ADDR, 8'hff);
    rd(UBC_PWR_ADDR, 8'hc0);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(UBC_RELOAD_ADDR, 8'hfe);
    rd(UBC_RELOAD_ADDR, 8'hfe);
    wr(UBC_T1_RELOAD_ADDR, 8'hfe);
    rd(UBC_T1_RELOAD_ADDR, 8'hfe);
    wr(UBC_T1_CTL_ADDR, 8'h01);
    wr(UBC_PWR_ADDR, 8'h00);
    $display("test registers done");
    // every serial mode, with receive enable and ninth bit
    for (int m = 0; m < 4; m++) begin
      v = {m[1:0], 6'h18};
      wr(UBC_SC_ADDR, v);
      rd(UBC_SC_ADDR, v);
      chk("mode", {14'h0, mode}, m[15:0]);
      chk("rx_enable", {15'h0, rx_enable}, 16'h1);
      chk("tx_ninth_bit", {15'h0, tx_ninth_bit}, 16'h1);
    end
    wr(UBC_SC_ADDR, 8'h68);
    #1 chk("multiproc", {15'h0, multiproc_enable}, 16'h1);
    $display("test modes done");
    // transmit flag, and set against a clear in the same cycle
    wr(UBC_SC_ADDR, 8'h50);
    shm_u.send_tx(2);
    #1 chk("tx_done_flag", {15'h0, tx_done_flag}, 16'h1);
    fork
      wr(UBC_SC_ADDR, 8'h50);
      shm_u.send_tx(0);
    join
    rd(UBC_SC_ADDR, 8'h52);
    wr(UBC_SC_ADDR, 8'h40);
    // receive disabled: frame ignored
    shm_u.recv(0, 1'b1, 1'b1, 1'b0);
    rd(UBC_SC_ADDR, 8'h40);
    // mode 3 keeps the ninth bit, mode 1 the stop bit
    wr(UBC_SC_ADDR, 8'hd0);
    shm_u.recv(3, 1'b1, 1'b0, 1'b0);
    rd(UBC_SC_ADDR, 8'hd5);
    wr(UBC_SC_ADDR, 8'h50);
    shm_u.recv(0, 1'b1, 1'b0, 1'b0);
    rd(UBC_SC_ADDR, 8'h51);
    shm_u.recv(0, 1'b0, 1'b1, 1'b0);
    rd(UBC_SC_ADDR, 8'h55);
    $display("test flags done");
    // framing error sticks across a good frame
    wr(UBC_PWR_ADDR, 8'h40);
    wr(UBC_SC_ADDR, 8'h50);
    shm_u.recv(0, 1'b0, 1'b0, 1'b1);
    shm_u.recv(1, 1'b0, 1'b1, 1'b0);
    #1 chk("framing_error", {15'h0, framing_error}, 16'h1);
    rd(UBC_SC_ADDR, 8'hd5);
    wr(UBC_SC_ADDR, 8'h50);
    rd(UBC_SC_ADDR, 8'h50);
    // bit 7 reaches the mode only while the check is off
    wr(UBC_PWR_ADDR, 8'h00);
    wr(UBC_SC_ADDR, 8'h80);
    wr(UBC_PWR_ADDR, 8'h40);
    wr(UBC_SC_ADDR, 8'h40);
    #1 chk("mode", {14'h0, mode}, 16'h3);
    rd(UBC_SC_ADDR, 8'h40);
    $display("test framing done");
    // bit rates from every source except the mode 0 generator path
    rate(8'h00, 8'h00, 8'h90, 1'b0, 32);
    rate(8'h80, 8'h00, 8'h90, 1'b0, 16);
    rate(8'h00, 8'h00, 8'h10, 1'b1, 6);
    rate(8'h00, 8'h1e, 8'h50, 1'b1, 64);
    rate(8'h80, 8'h1e, 8'h50, 1'b0, 32);
    rate(8'h00, 8'h16, 8'h50, 1'b0, 64);
    period(1'b1, n);
    chk("tx timer1", n[15:0], 16'd384);
    rate(8'h00, 8'h1c, 8'h50, 1'b1, 384);
    // generator halted: no transmit ticks at all
    wr(UBC_BAUD_ADDR, 8'h0e);
    // let an overflow already in flight drain before counting
    repeat (4) @(posedge clock);
    n = 0;
    repeat (300) begin
      @(posedge clock);
      #1 if (tx_bit_tick === 1'b1) n++;
    end
    chk("halted ticks", n[15:0], 16'h0);
    $display("test rates done");
    complete_run();
  end
endmodule
`default_nettype wire
